// ===== src/slcr_consts.svh
`ifndef SLCR_CONSTS_SVH
`define SLCR_CONSTS_SVH
// Register indices (word offsets on the register port)
`define SLCR_IDX_STAT     6'h00
`define SLCR_IDX_CW2      6'h01
`define SLCR_IDX_CW3      6'h02
`define SLCR_IDX_CW4      6'h03
`define SLCR_IDX_RLO      6'h04
`define SLCR_IDX_RHI      6'h05
`define SLCR_IDX_RUP      6'h06
`define SLCR_IDX_RDN      6'h07
`define SLCR_IDX_IRQ_ST   6'h20
`define SLCR_IDX_IRQ_MSK  6'h21
// Field positions
`define SLCR_LOCK_BIT     24
`define SLCR_RAMP_EN_BIT  19
`define SLCR_SYNC_PD_BIT  26
`define SLCR_CALCK_PD_BIT 25
`define SLCR_CAL_GO_BIT   24
`define SLCR_LD_EN_BIT    2
// Reset values
`define SLCR_CW3_RST      32'h0000_0000
`define SLCR_CW4_RST      32'h0000_0000
`define SLCR_CW2_RST      32'h0000_0000
// Lock window counts in reference-clock cycles
`define SLCR_LDW_0        11'd128
`define SLCR_LDW_1        11'd256
`define SLCR_LDW_2        11'd512
`define SLCR_LDW_3        11'd1024
`endif

// ===== src/slcr_pkg.sv
package slcr_pkg;
  typedef enum logic [1:0]
  {
    LK_OFF   = 2'b00,
    LK_COUNT = 2'b01,
    LK_HELD  = 2'b10
  } slcr_lock_e;
  typedef logic [31:0] slcr_word_t;
endpackage

// ===== src/slcr_ramp_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Four ramp parameter words with registered read data
module slcr_ramp_mem
  (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Write side
  input  wire logic        we,
  input  wire logic [1:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read side
  input  wire logic [1:0]  raddr,
  output var  logic [31:0] rdata,
  // All words in parallel for the ramp generator
  output var  logic [31:0] words [4]
  );

  logic [31:0] mem_q [4];
  logic [31:0] mem_d [4];
  logic [31:0] rdata_d;

  always_comb
  begin
    mem_d = mem_q;
    if (we)
    begin
      mem_d[waddr] = wdata;
    end
    rdata_d = mem_q[raddr];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        mem_q[i] <= 32'h0000_0000;
      end
      rdata <= 32'h0000_0000;
    end
    else
    begin
      mem_q <= mem_d;
      rdata <= rdata_d;
    end
  end

  assign words = mem_q;

endmodule
`default_nettype wire

// ===== src/slcr_regs.sv
// Notes on behaviour
// [RL1] Three-bit field selects charge pump current when manual selection is on.
// [RL2] Lock detection runs only while the lock-detect enable bit is one.
// [RL3] Lock after in-range phase error for 128, 256, 512 or 1024 ref cycles.
// [RL4] Lock status readable at bit 24 of register zero.
// [RL5] Bit 26 of control word four powers down the sync-output divider.
// [RL6] Calibration clock runs only while bits 25 and 26 are both zero.
// [RL7] Writing one to bit 24 of control word four starts calibration.
// [RL8] Software calibrates after power-up and after every system clock change.
// [RL9] Software writes bits 23..0 of control word four with their defaults.
// [RL10] Ramp limits and steps apply only while ramp enable bit 19 is one.
// [RL11] Ramp lower limit, 32 bits, at index 0x04.
// [RL12] Ramp upper limit, 32 bits, at index 0x05.
// [RL13] Rising step, 32 bits, at index 0x06.
// [RL14] Falling step, 32 bits, at index 0x07.
// [RL15] Lock clears when detection is off; window restarts when error leaves range.
//
// The strobed register port was left to the implementer.
`include "slcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module slcr_regs
  (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [5:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Phase detector side
  input  wire logic        ref_clk_pin,
  input  wire logic        phase_in_range,
  // Analogue controls
  output logic      [2:0]  pump_current_select,
  output logic             manual_pump_en,
  output logic             sync_div_pd,
  output logic             cal_clk_en,
  output logic             cal_start,
  output logic             locked,
  // Ramp generator parameters
  output logic             ramp_active,
  output logic      [31:0] ramp_lower,
  output logic      [31:0] ramp_upper,
  output logic      [31:0] ramp_rise,
  output logic      [31:0] ramp_fall,
  // Interrupt
  output logic             irq
  );

  // Control words
  logic [31:0]          cw2_q;
  logic [31:0]          cw2_d;
  logic [31:0]          cw3_q;
  logic [31:0]          cw3_d;
  logic [31:0]          cw4_q;
  logic [31:0]          cw4_d;
  // Interrupt status and mask
  logic [2:0]           ist_q;
  logic [2:0]           ist_d;
  logic [2:0]           imsk_q;
  logic [2:0]           imsk_d;
  // Synchronisers; the third reference stage only feeds the edge detector
  logic [2:0]           ref_sync_q;
  logic [2:0]           ref_sync_d;
  logic [1:0]           rng_sync_q;
  logic [1:0]           rng_sync_d;
  // Lock detector
  logic [10:0]          cnt_q;
  logic [10:0]          cnt_d;
  slcr_pkg::slcr_lock_e st_q;
  slcr_pkg::slcr_lock_e st_d;
  logic [10:0]          win;
  logic                 ref_rise;
  logic                 in_range;
  // Next values of the registered outputs
  logic                 locked_d;
  logic                 cal_d;
  logic                 sync_d;
  logic                 calck_d;
  logic                 mpe_d;
  logic                 irq_d;
  logic                 ract_d;
  logic [2:0]           pcs_d;
  logic [31:0]          rdata_d;
  logic [31:0]          rl_d;
  logic [31:0]          ru_d;
  logic [31:0]          rr_d;
  logic [31:0]          rf_d;
  // Ramp parameter store
  logic [31:0]          words [4];
  logic                 mem_we;

  function automatic logic [10:0] win_len(input logic [1:0] sel);
    case (sel)
      2'b00:   win_len = `SLCR_LDW_0;
      2'b01:   win_len = `SLCR_LDW_1;
      2'b10:   win_len = `SLCR_LDW_2;
      default: win_len = `SLCR_LDW_3;
    endcase
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
    hit = (a == idx);
  endfunction

  assign mem_we = wr && (addr[5:2] == 4'h1); // RL11 RL12 RL13 RL14

  slcr_ramp_mem u_mem
    (
    .clk    (clk),
    .arst_n (arst_n),
    .we     (mem_we),
    .waddr  (addr[1:0]),
    .wdata  (wdata),
    .raddr  (addr[1:0]),
    .rdata  (),
    .words  (words)
    );

  // Ref clock and range flag come from another domain: two stages each
  always_comb
  begin
    ref_sync_d = {ref_sync_q[1:0], ref_clk_pin};
    rng_sync_d = {rng_sync_q[0], phase_in_range};
    ref_rise   = ref_sync_q[1] && !ref_sync_q[2];
    in_range   = rng_sync_q[1];
  end

  // Lock detector, counted in reference-clock edges
  always_comb
  begin
    win   = win_len(cw3_q[1:0]); // RL3
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      slcr_pkg::LK_OFF:
      begin
        cnt_d = 11'd0;
        if (cw3_q[`SLCR_LD_EN_BIT])
        begin
          st_d = slcr_pkg::LK_COUNT;
        end
      end
      slcr_pkg::LK_COUNT:
      begin
        if (!in_range)
        begin
          cnt_d = 11'd0; // RL15
        end
        else if (ref_rise)
        begin
          cnt_d = cnt_q + 11'd1;
          if (cnt_q + 11'd1 >= win)
          begin
            st_d = slcr_pkg::LK_HELD; // RL3
          end
        end
      end
      slcr_pkg::LK_HELD:
      begin
        if (!in_range)
        begin
          st_d  = slcr_pkg::LK_COUNT; // RL15
          cnt_d = 11'd0;
        end
      end
      default:
      begin
        st_d  = slcr_pkg::LK_OFF;
        cnt_d = 11'd0;
      end
    endcase
    if (!cw3_q[`SLCR_LD_EN_BIT])
    begin
      st_d  = slcr_pkg::LK_OFF; // RL2 RL15
      cnt_d = 11'd0;
    end
    locked_d = (st_d == slcr_pkg::LK_HELD);
  end

  // Register writes, interrupt status and outputs
  always_comb
  begin
    cw2_d  = cw2_q;
    cw3_d  = cw3_q;
    cw4_d  = cw4_q;
    imsk_d = imsk_q;
    ist_d  = ist_q;
    cal_d  = 1'b0;
    if (wr && hit(addr, `SLCR_IDX_CW2))
    begin
      cw2_d = wdata;
    end
    if (wr && hit(addr, `SLCR_IDX_CW3))
    begin
      cw3_d = wdata;
    end
    if (wr && hit(addr, `SLCR_IDX_CW4))
    begin
      // Trigger bit is not stored so it reads back as zero
      cw4_d = {wdata[31:25], 1'b0, wdata[23:0]};
      cal_d = wdata[`SLCR_CAL_GO_BIT]; // RL7
    end
    if (wr && hit(addr, `SLCR_IDX_IRQ_MSK))
    begin
      imsk_d = wdata[2:0];
    end
    if (wr && hit(addr, `SLCR_IDX_IRQ_ST))
    begin
      ist_d = ist_q & ~wdata[2:0];
    end
    // Set wins over a same-cycle clear
    ist_d = ist_d | {cal_d, locked && !locked_d, locked_d && !locked};
    irq_d = |(ist_d & imsk_d);
    // Built from next values so controls settle one cycle after the write
    pcs_d   = cw3_d[5:3]; // RL1
    mpe_d   = cw3_d[6]; // RL1
    sync_d  = cw4_d[`SLCR_SYNC_PD_BIT]; // RL5
    calck_d = !cw4_d[`SLCR_CALCK_PD_BIT] && !cw4_d[`SLCR_SYNC_PD_BIT]; // RL6
    ract_d  = cw2_d[`SLCR_RAMP_EN_BIT]; // RL10
    // Parameters are forced to zero while the ramp is off
    rl_d = ract_d ? words[0] : 32'h0000_0000; // RL10
    ru_d = ract_d ? words[1] : 32'h0000_0000; // RL10
    rr_d = ract_d ? words[2] : 32'h0000_0000; // RL10
    rf_d = ract_d ? words[3] : 32'h0000_0000; // RL10
  end

  // Read data mux; ramp words come from the parallel store outputs
  // so that rdata stays one register deep like every other index
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        `SLCR_IDX_STAT:    rdata_d[`SLCR_LOCK_BIT] = locked; // RL4
        `SLCR_IDX_CW2:     rdata_d = cw2_q;
        `SLCR_IDX_CW3:     rdata_d = cw3_q;
        `SLCR_IDX_CW4:     rdata_d = cw4_q;
        `SLCR_IDX_RLO:     rdata_d = words[0]; // RL11
        `SLCR_IDX_RHI:     rdata_d = words[1]; // RL12
        `SLCR_IDX_RUP:     rdata_d = words[2]; // RL13
        `SLCR_IDX_RDN:     rdata_d = words[3]; // RL14
        `SLCR_IDX_IRQ_ST:  rdata_d[2:0] = ist_q;
        `SLCR_IDX_IRQ_MSK: rdata_d[2:0] = imsk_q;
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cw2_q               <= `SLCR_CW2_RST;
      cw3_q               <= `SLCR_CW3_RST;
      cw4_q               <= `SLCR_CW4_RST;
      imsk_q              <= 3'h0;
      ist_q               <= 3'h0;
      ref_sync_q          <= 3'h0;
      rng_sync_q          <= 2'h0;
      cnt_q               <= 11'd0;
      st_q                <= slcr_pkg::LK_OFF;
      locked              <= 1'b0;
      cal_start           <= 1'b0;
      pump_current_select <= 3'h0;
      manual_pump_en      <= 1'b0;
      sync_div_pd         <= 1'b0;
      cal_clk_en          <= 1'b0;
      ramp_active         <= 1'b0;
      ramp_lower          <= 32'h0000_0000;
      ramp_upper          <= 32'h0000_0000;
      ramp_rise           <= 32'h0000_0000;
      ramp_fall           <= 32'h0000_0000;
      irq                 <= 1'b0;
      rdata               <= 32'h0000_0000;
    end
    else
    begin
      cw2_q               <= cw2_d;
      cw3_q               <= cw3_d;
      cw4_q               <= cw4_d;
      imsk_q              <= imsk_d;
      ist_q               <= ist_d;
      ref_sync_q          <= ref_sync_d;
      rng_sync_q          <= rng_sync_d;
      cnt_q               <= cnt_d;
      st_q                <= st_d;
      locked              <= locked_d;
      cal_start           <= cal_d;
      pump_current_select <= pcs_d;
      manual_pump_en      <= mpe_d;
      sync_div_pd         <= sync_d;
      cal_clk_en          <= calck_d;
      ramp_active         <= ract_d;
      ramp_lower          <= rl_d;
      ramp_upper          <= ru_d;
      ramp_rise           <= rr_d;
      ramp_fall           <= rf_d;
      irq                 <= irq_d;
      rdata               <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ===== verif/slcr_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module slcr_regs_chk
  (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Register port
  input wire logic [5:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Controls
  input wire logic [2:0]  pump_current_select,
  input wire logic        sync_div_pd,
  input wire logic        cal_clk_en,
  input wire logic        cal_start,
  input wire logic        locked,
  input wire logic        ramp_active,
  input wire logic [31:0] ramp_lower,
  input wire logic [31:0] ramp_upper
  );
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic w3;
  logic w3_go;
  assign w3    = wr && addr == 6'h03;
  assign w3_go = w3 && wdata[24];
  property p_cal_go; w3_go |=> cal_start; endproperty
  a_cal_go: assert property (p_cal_go) else $error("cal_start missing");
  property p_cal_only; cal_start |-> $past(w3_go); endproperty
  a_cal_only: assert property (p_cal_only) else $error("cal_start unprovoked");
  property p_sync; w3 |=> sync_div_pd == $past(wdata[26]); endproperty
  a_sync: assert property (p_sync) else $error("sync_div_pd wrong");
  property p_calclk; w3 |=> cal_clk_en == !($past(wdata[25]) || $past(wdata[26])); endproperty
  a_calclk: assert property (p_calclk) else $error("cal_clk_en wrong");
  property p_calexcl; cal_clk_en |-> !sync_div_pd; endproperty
  a_calexcl: assert property (p_calexcl) else $error("cal clock with divider off");
  property p_pump; wr && addr == 6'h02 |=> pump_current_select == $past(wdata[5:3]); endproperty
  a_pump: assert property (p_pump) else $error("pump select wrong");
  property p_lock_off; wr && addr == 6'h02 && !wdata[2] |-> ##[1:4] !locked; endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock kept while off");
  property p_lock_rd; rd && addr == 6'h00 ##1 $stable(locked) |-> rdata[24] == locked; endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("lock bit read wrong");
  property p_ramp_off; !ramp_active [*3] |-> ramp_lower == 32'h0 && ramp_upper == 32'h0; endproperty
  a_ramp_off: assert property (p_ramp_off) else $error("ramp words while off");
  c_cal: cover property (cal_start);
  c_lock: cover property ($rose(locked));
  c_ramp: cover property (ramp_active && ramp_lower != 32'h0);
endmodule
bind slcr_regs slcr_regs_chk chk_u (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
  .pump_current_select, .sync_div_pd, .cal_clk_en, .cal_start, .locked, .ramp_active,
  .ramp_lower, .ramp_upper);
`default_nettype wire

// ===== verif/test_slcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_slcr_regs;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
  logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        ref_clk_pin = 1'b0, phase_in_range = 1'b0;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, ramp_lower, ramp_upper, ramp_rise, ramp_fall;
  logic [2:0]  pump_current_select;
  logic        manual_pump_en, sync_div_pd, cal_clk_en, cal_start, locked, ramp_active, irq;
  int          err_count = 0, comparisons = 0;
  slcr_regs dut_u (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .ref_clk_pin,
    .phase_in_range, .pump_current_select, .manual_pump_en, .sync_div_pd, .cal_clk_en,
    .cal_start, .locked, .ramp_active, .ramp_lower, .ramp_upper, .ramp_rise, .ramp_fall, .irq);
  always #2 clk = ~clk;
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata)
  endtask
  // Reference clock at a quarter of the system rate, two cycles high and two low
  task automatic ref_edges(input int n);
    repeat (n)
    begin
      @(posedge clk);
      ref_clk_pin <= 1'b1;
      repeat (2) @(posedge clk);
      ref_clk_pin <= 1'b0;
      @(posedge clk);
    end
    @(negedge clk);
  endtask
  task automatic t_cw4;
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(6'h03, {5'h0, i[1:0], 1'b1, 24'h0});
      @(negedge clk);
      `CHK("cal_start", 1'b1, cal_start)
      `CHK("sync_div_pd", i[1], sync_div_pd)
      `CHK("cal_clk_en", i == 0, cal_clk_en)
      @(negedge clk);
      `CHK("cal_start", 1'b0, cal_start)
    end
    rd_chk(6'h03, 32'h0600_0000);
    wr_reg(6'h3f, 32'hffff_ffff);
    rd_chk(6'h3f, 32'h0);
    `CHK("irq", 1'b0, irq)
    wr_reg(6'h21, 32'h4);
    repeat (2) @(negedge clk);
    `CHK("irq", 1'b1, irq)
    rd_chk(6'h20, 32'h4);
    wr_reg(6'h20, 32'h4);
    repeat (2) @(negedge clk);
    `CHK("irq", 1'b0, irq)
    $display("test cw4 done");
  endtask
  task automatic t_ramp;
    for (int i = 4; i < 8; i++)
      wr_reg(i[5:0], 32'hc0de_0000 + i);
    for (int i = 4; i < 8; i++)
      rd_chk(i[5:0], 32'hc0de_0000 + i);
    repeat (3) @(negedge clk);
    `CHK("ramp_lower", 32'h0, ramp_lower)
    `CHK("ramp_active", 1'b0, ramp_active)
    wr_reg(6'h01, 32'h0008_0000);
    repeat (3) @(negedge clk);
    `CHK("ramp_active", 1'b1, ramp_active)
    `CHK("ramp_lower", 32'hc0de_0004, ramp_lower)
    `CHK("ramp_upper", 32'hc0de_0005, ramp_upper)
    `CHK("ramp_rise", 32'hc0de_0006, ramp_rise)
    `CHK("ramp_fall", 32'hc0de_0007, ramp_fall)
    wr_reg(6'h01, 32'h0);
    repeat (3) @(negedge clk);
    `CHK("ramp_upper", 32'h0, ramp_upper)
    `CHK("ramp_active", 1'b0, ramp_active)
    $display("test ramp done");
  endtask
  task automatic t_lock(input logic [1:0] w);
    int n;
    n = 128 << w;
    wr_reg(6'h02, {25'h0, 1'b1, 3'h5, 1'b1, w});
    phase_in_range <= 1'b1;
    @(negedge clk);
    `CHK("pump", 3'h5, pump_current_select)
    `CHK("manual", 1'b1, manual_pump_en)
    ref_edges(n - 4);
    `CHK("locked", 1'b0, locked)
    ref_edges(8);
    `CHK("locked", 1'b1, locked)
    rd_chk(6'h00, 32'h0100_0000);
    @(posedge clk);
    phase_in_range <= 1'b0;
    ref_edges(2);
    `CHK("locked", 1'b0, locked)
    @(posedge clk);
    phase_in_range <= 1'b1;
    ref_edges(n - 4);
    `CHK("locked", 1'b0, locked)
    ref_edges(8);
    `CHK("locked", 1'b1, locked)
    wr_reg(6'h02, {30'h0, w});
    ref_edges(n + 4);
    `CHK("locked", 1'b0, locked)
    @(posedge clk);
    phase_in_range <= 1'b0;
    $display("test lock window %0d done", n);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #200_000;
    err_count++;
    $display("wrong value watchdog exp %h got %h", 1'b0, 1'b1);
    final_report;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_cw4;
    t_ramp;
    for (int w = 0; w < 4; w++)
      t_lock(w[1:0]);
    final_report;
  end
endmodule
`default_nettype wire
